// ===== include/lfs_pkg.sv
// Package for the LED fault supervisor: timing counts and state encodings.
// Assumes a 125 MHz system clock shared by both ends.
package lfs_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 125;
    localparam int IDLE_TIME_US   = 4000;
    localparam int HOLD_TIME_US   = 128000;
    localparam int SOFT_TIME_US   = 200;
    localparam int IDLE_CYCLES    = IDLE_TIME_US * CLK_MHZ;
    localparam int HOLD_CYCLES    = HOLD_TIME_US * CLK_MHZ;
    localparam int SOFT_CYCLES    = SOFT_TIME_US * CLK_MHZ;
    localparam int NUM_CH         = 2;
    localparam int RAMP_W         = 8;
    localparam logic [RAMP_W-1:0] RAMP_FULL = 8'hFF;

    // ------------------------------------------------------------
    // Per-channel state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LFS_CH_RUN  = 2'b00,
        LFS_CH_HOLD = 2'b01
    } lfs_ch_state_t;

    // ------------------------------------------------------------
    // Device-level state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LFS_DEV_LOCKOUT = 2'b00,
        LFS_DEV_ACTIVE  = 2'b01,
        LFS_DEV_THERMAL = 2'b10,
        LFS_DEV_LOWPWR  = 2'b11
    } lfs_dev_state_t;

endpackage : lfs_pkg

// ===== include/lfs_link_if.sv
// Interface joining host and device: dimming lines and shared open-drain fault line.
// Assumes a pull-up; the wire is low when the device enables its driver.
`timescale 1ns/1ps
interface lfs_link_if #(parameter int NCH = 2);
    logic [NCH-1:0] channelDimInput;
    logic           devFaultOut;
    logic           devFaultOe_n;
    logic           sharedFaultLine_n;

    // Pull-up resolution: active-low enable pulls the wire to the driven low level
    assign sharedFaultLine_n = devFaultOe_n ? 1'b1 : devFaultOut;

    modport device (input channelDimInput, input sharedFaultLine_n,
                    output devFaultOut, output devFaultOe_n);
    modport host   (output channelDimInput, input sharedFaultLine_n);
endinterface : lfs_link_if

// ===== rtl/lfs_host_end.sv
// Host end: passes per-channel PWM from the user side onto the dimming lines
// and reports the shared fault line. Assumes inputs synchronous to clk_sys.
`timescale 1ns/1ps
module lfs_host_end
    import lfs_pkg::*;
#(
    parameter int NCH = NUM_CH
) (
    input  wire logic     clk_sys,
    input  wire logic     rst_n,
    lfs_link_if.host      link,
    input  wire logic [NCH-1:0] userPwm,
    output logic          faultSeen,
    output logic          faultRise
);
    logic [NCH-1:0] dim_q, dim_d;
    logic           seen_q, seen_d, rise_q, rise_d;

    // Elaboration check: at least one dimming line
    if (NCH < 1) begin : g_bad_nch
        $error("NCH must be at least 1");
    end

    // Separate waveform per channel; tied strings get identical userPwm bits
    always_comb begin
        dim_d  = userPwm;
        seen_d = ~link.sharedFaultLine_n;
        rise_d = seen_d & ~seen_q;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dim_q  <= '0;
            seen_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            dim_q  <= dim_d;
            seen_q <= seen_d;
            rise_q <= rise_d;
        end
    end

    assign link.channelDimInput = dim_q;
    assign faultSeen = seen_q;
    assign faultRise = rise_q;
endmodule : lfs_host_end

// ===== rtl/lfs_device_end.sv
// Device end: fault supervisor gating each channel sink from comparator flags.
// Assumes flags and dimming lines are asynchronous and are synchronised here.
`timescale 1ns/1ps
module lfs_device_end
    import lfs_pkg::*;
#(
    parameter int NCH      = NUM_CH,
    parameter int IDLE_CYC = IDLE_CYCLES,
    parameter int HOLD_CYC = HOLD_CYCLES,
    parameter int SOFT_CYC = SOFT_CYCLES
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    lfs_link_if.device                link,
    input  wire logic                 supplyGood,
    input  wire logic                 overTemp,
    input  wire logic                 tempRecovered,
    input  wire logic [NCH-1:0]       ledOpen,
    input  wire logic [NCH-1:0]       ledShort,
    output logic [NCH-1:0]            channelSinkOutput,
    output logic [NCH-1:0][RAMP_W-1:0] sinkLevel,
    output logic                      lowPower,
    output logic                      thermalShutdown
);
    // Floor division so the ramp ends within SOFT_CYC, never after it
    localparam int SOFT_STEP = SOFT_CYC / int'(RAMP_FULL);

    // Elaboration checks: the ramp needs at least one cycle per level
    if (NCH < 1 || NCH > 8) begin : g_bad_nch
        $error("NCH out of range");
    end
    if (IDLE_CYC < 1 || HOLD_CYC < 1 || SOFT_CYC < int'(RAMP_FULL)) begin : g_bad_cnt
        $error("counts out of range");
    end

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    localparam int SW = 3 + 3 * NCH;
    logic [SW-1:0] sA_q, sB_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sA_q <= '0;
            sB_q <= '0;
        end else begin
            sA_q <= {supplyGood, overTemp, tempRecovered, ledOpen, ledShort,
                     link.channelDimInput};
            sB_q <= sA_q;
        end
    end
    logic           sGood, sHot, sCool;
    logic [NCH-1:0] sOpen, sShort, sDim;
    assign {sGood, sHot, sCool, sOpen, sShort, sDim} = sB_q;

    // ------------------------------------------------------------
    // Device state and counters
    // ------------------------------------------------------------
    lfs_dev_state_t dev_q, dev_d;
    logic [31:0]    idle_q, idle_d;
    logic [31:0]    soft_q, soft_d;
    logic [RAMP_W-1:0] ramp_q, ramp_d;

    always_comb begin
        dev_d  = dev_q;
        idle_d = idle_q;
        soft_d = soft_q;
        ramp_d = ramp_q;
        if (|sDim) idle_d = '0;
        else if (idle_q < 32'(IDLE_CYC)) idle_d = idle_q + 32'd1;
        // Soft-start ramp: one level step per SOFT_STEP cycles
        if (ramp_q != RAMP_FULL) begin
            if (soft_q >= 32'(SOFT_STEP - 1)) begin
                soft_d = '0;
                ramp_d = ramp_q + 8'h01;
            end else begin
                soft_d = soft_q + 32'd1;
            end
        end
        case (dev_q)
            LFS_DEV_LOCKOUT: begin
                ramp_d = '0;
                soft_d = '0;
                if (sGood) dev_d = LFS_DEV_LOWPWR;
            end
            LFS_DEV_ACTIVE: begin
                if (idle_q >= 32'(IDLE_CYC)) dev_d = LFS_DEV_LOWPWR;
            end
            LFS_DEV_THERMAL: begin
                ramp_d = '0;
                soft_d = '0;
                if (sCool && !sHot) dev_d = LFS_DEV_ACTIVE;
            end
            LFS_DEV_LOWPWR: begin
                ramp_d = '0;
                soft_d = '0;
                if (|sDim) dev_d = LFS_DEV_ACTIVE;
            end
            default: dev_d = LFS_DEV_LOCKOUT;
        endcase
        // Overrides: overtemperature first, then supply loss, which wins
        if (dev_q != LFS_DEV_LOCKOUT && sHot) begin
            dev_d  = LFS_DEV_THERMAL;
            ramp_d = '0;
        end
        if (!sGood) begin
            dev_d  = LFS_DEV_LOCKOUT;
            ramp_d = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dev_q  <= LFS_DEV_LOCKOUT;
            idle_q <= '0;
            soft_q <= '0;
            ramp_q <= '0;
        end else begin
            dev_q  <= dev_d;
            idle_q <= idle_d;
            soft_q <= soft_d;
            ramp_q <= ramp_d;
        end
    end

    // ------------------------------------------------------------
    // Per-channel fault hold and retest
    // ------------------------------------------------------------
    logic [NCH-1:0] hold_q, hold_d, sink_q, sink_d;
    logic [NCH-1:0][RAMP_W-1:0] lvl_q, lvl_d;
    logic [NCH-1:0][31:0] hcnt_q, hcnt_d;
    logic running;
    assign running = (dev_q == LFS_DEV_ACTIVE);

    // Each channel has its own hold timer so a fault stays local
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        always_comb begin
            hold_d[c] = hold_q[c];
            hcnt_d[c] = hcnt_q[c];
            if (!hold_q[c]) begin
                if (running && (sOpen[c] || sShort[c])) begin
                    hold_d[c] = 1'b1;
                    hcnt_d[c] = '0;
                end
            end else if (hcnt_q[c] >= 32'(HOLD_CYC - 1)) begin
                // Retest: stay held for another interval if still faulty
                hcnt_d[c] = '0;
                if (!(sOpen[c] || sShort[c])) hold_d[c] = 1'b0;
            end else begin
                hcnt_d[c] = hcnt_q[c] + 32'd1;
            end
            sink_d[c] = running && !hold_d[c] && sDim[c];
            lvl_d[c]  = sink_d[c] ? ramp_q : '0;
        end
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                hold_q[c] <= 1'b0;
                hcnt_q[c] <= '0;
                sink_q[c] <= 1'b0;
                lvl_q[c]  <= '0;
            end else begin
                hold_q[c] <= hold_d[c];
                hcnt_q[c] <= hcnt_d[c];
                sink_q[c] <= sink_d[c];
                lvl_q[c]  <= lvl_d[c];
            end
        end
    end

    // ------------------------------------------------------------
    // Fault line and status
    // ------------------------------------------------------------
    logic oe_n_q, oe_n_d, lp_q, lp_d, th_q, th_d;
    always_comb begin
        oe_n_d = !((dev_d == LFS_DEV_LOCKOUT)
                 || (dev_d == LFS_DEV_THERMAL)
                 || (|hold_d));
        lp_d   = (dev_d == LFS_DEV_LOWPWR);
        th_d   = (dev_d == LFS_DEV_THERMAL);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            oe_n_q <= 1'b0;
            lp_q   <= 1'b0;
            th_q   <= 1'b0;
        end else begin
            oe_n_q <= oe_n_d;
            lp_q   <= lp_d;
            th_q   <= th_d;
        end
    end

    // Driven level is always low; only the enable moves
    assign link.devFaultOut  = 1'b0;
    assign link.devFaultOe_n = oe_n_q;
    assign channelSinkOutput = sink_q;
    assign sinkLevel         = lvl_q;
    assign lowPower          = lp_q;
    assign thermalShutdown   = th_q;
endmodule : lfs_device_end

// ===== tb/lfs_link_checker.sv
// Checker for the host/device link: open-drain fault line and reset behaviour.
// Assumes instantiation beside the link interface, one clock domain.
`timescale 1ns/1ps
module lfs_link_checker #(
    parameter int NCH = 2
) (
    input wire logic           clk_sys,
    input wire logic           rst_n,
    input wire logic [NCH-1:0] channelDimInput,
    input wire logic           devFaultOut,
    input wire logic           devFaultOe_n,
    input wire logic           sharedFaultLine_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    drive_low_only_a: assert property (devFaultOut == 1'b0)
        else $error("fault driver level is not low");
    line_follows_en_a: assert property (sharedFaultLine_n == devFaultOe_n)
        else $error("fault line differs from driver enable");
    lockout_fault_a: assert property ($rose(rst_n) |-> !devFaultOe_n ##1 !devFaultOe_n)
        else $error("fault line released during lockout");
    // Supply flag must cross both synchroniser stages before lockout can end
    lockout_sync_a: assert property ($rose(rst_n) |-> ##2 !devFaultOe_n)
        else $error("supply flag acted before synchronisation");
    dims_idle_a: assert property ($rose(rst_n) |-> channelDimInput == '0)
        else $error("dimming lines not idle after reset");
    // Bus sharing: a low line must be explained by our own enable
    line_cause_a: assert property (!sharedFaultLine_n |-> !devFaultOe_n)
        else $error("fault line low without a driver");
    released_high_a: assert property (devFaultOe_n |-> sharedFaultLine_n)
        else $error("released fault line not pulled high");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    fault_set_c: cover property ($fell(sharedFaultLine_n));
    fault_clr_c: cover property ($rose(sharedFaultLine_n));
    dims_all_c:  cover property (channelDimInput == '1);
endmodule : lfs_link_checker

// ===== tb/testbench.sv
// Self-checking bench: host end and device end joined by the link interface.
// Assumes short parameter counts so hold, idle and ramp fit in a short run.
`timescale 1ns/1ps
module testbench;
    import lfs_pkg::*;
    localparam int IDLE = 50;
    localparam int HOLD = 100;
    localparam int SOFT = 300;
    logic                   clk_sys, rst_n, supplyGood, overTemp, tempRecovered;
    logic                   faultSeen, faultRise, lowPower, thermalShutdown;
    logic [1:0]             ledOpen, ledShort, userPwm, channelSinkOutput;
    logic [1:0][RAMP_W-1:0] sinkLevel;
    logic [31:0]            rnd = 32'h6CE634E4;
    int                     nFail = 0;
    int                     checkCount = 0;
    logic [6:0]             expQ[$];
    logic [4:0]             riseCount = 5'h00;
    event                   chk;

    lfs_link_if #(.NCH(2)) link ();
    lfs_host_end #(.NCH(2)) lfs_host_end_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
        .userPwm(userPwm), .faultSeen(faultSeen), .faultRise(faultRise));
    lfs_device_end #(.NCH(2), .IDLE_CYC(IDLE), .HOLD_CYC(HOLD), .SOFT_CYC(SOFT))
        lfs_device_end_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
        .supplyGood(supplyGood), .overTemp(overTemp), .tempRecovered(tempRecovered),
        .ledOpen(ledOpen), .ledShort(ledShort), .channelSinkOutput(channelSinkOutput),
        .sinkLevel(sinkLevel), .lowPower(lowPower), .thermalShutdown(thermalShutdown));
    lfs_link_checker #(.NCH(2)) lfs_link_checker_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .channelDimInput(link.channelDimInput), .devFaultOut(link.devFaultOut),
        .devFaultOe_n(link.devFaultOe_n), .sharedFaultLine_n(link.sharedFaultLine_n));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xorshift(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xorshift

    task automatic cyc(int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc

    // State note: {fault seen, thermal, low power, sinks}
    task automatic expect_state(logic [4:0] e);
        expQ.push_back({2'h0, e});
        ->chk;
    endtask : expect_state

    // Ramp note: one bit per channel, set when that level is full
    task automatic expect_ramp(logic [1:0] e);
        expQ.push_back({2'h1, 3'h0, e});
        ->chk;
    endtask : expect_ramp

    // Count note: new-fault pulses seen by the host so far
    task automatic expect_count(logic [4:0] e);
        expQ.push_back({2'h2, e});
        ->chk;
    endtask : expect_count

    task automatic compare_count(logic [4:0] e, logic [4:0] g);
        checkCount++;
        if (g !== e) begin
            nFail++;
            $display("mismatch faultRise count expected %0d seen %0d", e, g);
        end
    endtask : compare_count

    task automatic compare_state(logic [4:0] e, logic [4:0] g);
        checkCount++;
        if (g !== e) begin
            nFail++;
            $display("mismatch state expected %b seen %b", e, g);
        end
    endtask : compare_state

    task automatic compare_ramp(logic [1:0] e, logic [1:0] g);
        checkCount++;
        if (g !== e) begin
            nFail++;
            $display("mismatch rampFull expected %b seen %b", e, g);
        end
    endtask : compare_ramp

    task automatic final_report();
        $display("checks %0d mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // Clock, monitor, watchdog
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    initial begin
        logic [6:0] n;
        logic [4:0] st;
        logic [1:0] rf;
        forever begin
            @(chk);
            // Drain every note: two notes may be posted in one time step
            while (expQ.size() > 0) begin
                n  = expQ.pop_front();
                st = {faultSeen, thermalShutdown, lowPower, channelSinkOutput};
                rf = {sinkLevel[1] == RAMP_FULL, sinkLevel[0] == RAMP_FULL};
                if (n[6:5] == 2'h1) begin
                    compare_ramp(n[1:0], rf);
                end else if (n[6:5] == 2'h2) begin
                    compare_count(n[4:0], riseCount);
                end else begin
                    compare_state(n[4:0], st);
                end
            end
        end
    end

    // New-fault pulses are counted where they have settled
    always @(negedge clk_sys) begin
        if (faultRise) riseCount <= riseCount + 5'h01;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        nFail++;
        final_report();
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        {supplyGood, overTemp, ledOpen, ledShort, userPwm, rst_n} = '0;
        tempRecovered = 1'b1;
        cyc(12);
        rst_n = 1'b1;
        cyc(5);
        expect_state(5'b10000);
        supplyGood = 1'b1;
        cyc(8);
        expect_state(5'b00100);
        for (int i = 0; i < 4; i++) begin
            rnd = xorshift(rnd);
            userPwm = rnd[1:0] | 2'b01;
            cyc(8);
            expect_state({3'b000, userPwm});
            if (i == 0) expect_ramp(2'h0);
        end
        userPwm = 2'b11;
        // Half way through the soft start no channel may be at full level
        cyc(SOFT / 2);
        expect_ramp(2'h0);
        cyc(SOFT / 2);
        expect_ramp(2'h3);
        // Faults are one-shot glitches: retest must see them gone
        for (int k = 0; k < 2; k++) begin
            if (k == 0) ledOpen[0] = 1'b1;
            else ledShort[1] = 1'b1;
            cyc(8);
            expect_state(k ? 5'b10001 : 5'b10010);
            {ledOpen, ledShort} = '0;
            cyc(HOLD - 20);
            expect_state(k ? 5'b10001 : 5'b10010);
            cyc(30);
            expect_state(5'b00011);
        end
        // A fault still present at the retest keeps the channel held
        ledOpen[0] = 1'b1;
        cyc(HOLD + 20);
        expect_state(5'b10010);
        ledOpen[0] = 1'b0;
        cyc(HOLD);
        expect_state(5'b00011);
        {overTemp, tempRecovered} = 2'b10;
        cyc(8);
        expect_state(5'b11000);
        overTemp = 1'b0;
        cyc(20);
        expect_state(5'b11000);
        tempRecovered = 1'b1;
        cyc(8);
        expect_state(5'b00011);
        expect_ramp(2'h0);
        userPwm = 2'b00;
        cyc(IDLE - 20);
        expect_state(5'b00000);
        cyc(30);
        expect_state(5'b00100);
        userPwm = 2'b11;
        cyc(8);
        expect_state(5'b00011);
        supplyGood = 1'b0;
        cyc(8);
        expect_state(5'b10000);
        cyc(2);
        // Lockout, open, short, persistent open, thermal, supply loss
        expect_count(5'h06);
        cyc(1);
        final_report();
    end
endmodule : testbench
